// [spipw_consts.vh]
// constants for the serial nonvolatile memory command and protection block
// assumes a 20 MHz system clock and a 16-bit address space with 128-byte pages
`ifndef SPIPW_CONSTS_VH
`define SPIPW_CONSTS_VH

// instruction opcodes
`define SPIPW_OP_SET_WEL 8'h06
`define SPIPW_OP_CLR_WEL 8'h04
`define SPIPW_OP_SR_READ 8'h05
`define SPIPW_OP_SR_WRITE 8'h01
`define SPIPW_OP_MEM_READ 8'h03
`define SPIPW_OP_MEM_WRITE 8'h02

// status and protection register bit positions
`define SPIPW_SR_HWP_EN 7
`define SPIPW_SR_ID_SEL 6
`define SPIPW_SR_ZERO 5
`define SPIPW_SR_ID_LOCK 4
`define SPIPW_SR_BP_HIGH 3
`define SPIPW_SR_BP_LOW 2
`define SPIPW_SR_WEL 1
`define SPIPW_SR_BUSY 0

// bits that a status write may alter
`define SPIPW_SR_WRITE_MASK 8'hdc

// reset values of the stored bits
`define SPIPW_RST_BP 2'h0
`define SPIPW_RST_ID_LOCK 1'b0
`define SPIPW_RST_HWP_EN 1'b0

// block-protect boundaries
`define SPIPW_BP_QUARTER 16'hc000
`define SPIPW_BP_HALF 16'h8000

// page geometry
`define SPIPW_PAGE_BYTES 128

// timing: clock rate and write cycle time
`define SPIPW_CLK_HZ 20000000
`define SPIPW_TWC_MS 5

`endif

// [spipw_core.v]
// serial nonvolatile memory slave: instruction decode, status and protection
// register, write latch, block and hardware protection, page load with wrap,
// identification page select and lock, and a 4-word programming queue.
// assumes serial pins arrive asynchronous to i_clock and that a cell
// programmer downstream takes one byte per o_prog_valid/i_prog_ready beat.
`timescale 1ns/1ps
`include "spipw_consts.vh"

// small first-in first-out queue with valid and ready on both sides
module spipw_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // clock and reset
    input wire i_clock,
    input wire i_rst_b,
    // fill side
    input wire i_in_valid,
    input wire [WIDTH-1:0] i_in_data,
    output wire o_in_ready,
    // drain side
    output wire o_out_valid,
    output wire [WIDTH-1:0] o_out_data,
    input wire i_out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // honest full and empty from the word count
    assign o_in_ready = (count != DEPTH[AW:0]);
    assign o_out_valid = (count != {(AW+1){1'b0}});
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid & o_in_ready;
    assign pop = o_out_valid & i_out_ready;

    // storage, no reset needed
    always @(posedge i_clock) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    // pointers and count
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule

module spipw_core #(
    parameter WRITE_CYCLES = `SPIPW_TWC_MS * (`SPIPW_CLK_HZ / 1000)
) (
    // clock and reset
    input wire i_clock,
    input wire i_rst_b,
    // serial bus pins
    input wire i_sck,
    input wire i_cs_b,
    input wire i_si,
    input wire i_wp_b,
    output reg o_so,
    output wire o_so_oe,
    // cell programming port
    output wire o_prog_valid,
    output wire [15:0] o_prog_addr,
    output wire o_prog_id_page,
    output wire [7:0] o_prog_data,
    input wire i_prog_ready,
    // status view
    output wire [7:0] o_status
);
    localparam ST_OP = 3'h0;
    localparam ST_ADDR_HI = 3'h1;
    localparam ST_ADDR_LO = 3'h2;
    localparam ST_DATA = 3'h3;
    localparam ST_SR_WR = 3'h4;
    localparam ST_SR_RD = 3'h5;
    localparam ST_IGNORE = 3'h6;
    localparam [19:0] TWC_COUNT = WRITE_CYCLES[19:0];

    // reset release through two flip-flops
    reg [1:0] rst_sync;
    wire rst_b;
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_b = rst_sync[1];

    // two-stage synchronisers for the four pins: sck, cs, si, wp
    wire [3:0] pin_raw;
    reg [3:0] pin_meta;
    reg [3:0] pin_sync;
    assign pin_raw = {i_wp_b, i_si, i_cs_b, i_sck};
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_sync
            always @(posedge i_clock or negedge rst_b) begin
                if (!rst_b) begin
                    pin_meta[g] <= (g == 1) ? 1'b1 : 1'b0; // select idles high
                    pin_sync[g] <= (g == 1) ? 1'b1 : 1'b0;
                end else begin
                    pin_meta[g] <= pin_raw[g];
                    pin_sync[g] <= pin_meta[g];
                end
            end
        end
    endgenerate

    // edge detection on the synchronised copies
    reg sck_d;
    reg cs_d;
    wire sck_rise;
    wire sck_fall;
    wire cs_low;
    wire cs_rise;
    wire wp_high;
    always @(posedge i_clock or negedge rst_b) begin
        if (!rst_b) begin
            sck_d <= 1'b0;
            cs_d <= 1'b1;
        end else begin
            sck_d <= pin_sync[0];
            cs_d <= pin_sync[1];
        end
    end
    assign cs_low = ~pin_sync[1];
    assign sck_rise = pin_sync[0] & ~sck_d & cs_low;
    assign sck_fall = ~pin_sync[0] & sck_d & cs_low;
    assign cs_rise = pin_sync[1] & ~cs_d;
    assign wp_high = pin_sync[3];

    // frame state
    reg [2:0] state;
    reg [2:0] bit_cnt;
    reg [6:0] shift_in;
    reg [15:0] addr;
    reg [6:0] col;
    reg [6:0] start_col;
    reg [7:0] loaded;
    reg is_write;
    reg wel_pend;
    reg [7:0] sr_new;
    reg sr_got;
    reg [7:0] so_shift;
    // status bits
    reg write_enable_latch_bit;
    reg busy;
    reg [1:0] bp;
    reg id_lock;
    reg id_sel;
    reg hwp_en;
    // write cycle
    reg [19:0] timer;
    reg [6:0] feed_col;
    reg [7:0] feed_left;
    reg [15:0] feed_page;
    reg feed_id;
    reg [7:0] page_buf [0:`SPIPW_PAGE_BYTES-1];

    wire [7:0] new_byte;
    wire [7:0] status_val;
    wire byte_done;
    wire feeding;
    wire fifo_in_ready;
    wire [24:0] fifo_in;
    wire [24:0] fifo_out;
    wire [15:0] tgt;
    wire tgt_protected;
    wire mem_ok;
    wire sr_ok;
    wire [7:0] sr_merged;

    wire i_si_s;
    assign i_si_s = pin_sync[2];
    assign new_byte = {shift_in, i_si_s};
    assign byte_done = sck_rise & (bit_cnt == 3'h7);
    assign feeding = (feed_left != 8'h00);

    // status layout, bit 5 always zero
    assign status_val = {hwp_en, id_sel, 1'b0, id_lock, bp, write_enable_latch_bit, busy};
    assign o_status = status_val;

    // protection of the target; id page checks its seven-bit offset
    assign tgt = id_sel ? {9'h000, addr[6:0]} : addr;
    assign tgt_protected = (bp == 2'h3) ||
                           (bp == 2'h2 && tgt >= `SPIPW_BP_HALF) ||
                           (bp == 2'h1 && tgt >= `SPIPW_BP_QUARTER);
    assign mem_ok = write_enable_latch_bit & ~tgt_protected & ~(id_sel & id_lock);
    assign sr_ok = write_enable_latch_bit & (~hwp_en | wp_high);

    // merged status write: only writable bits, select plus lock both held
    assign sr_merged[7] = sr_new[`SPIPW_SR_HWP_EN];
    assign sr_merged[6] = (sr_new[6] & sr_new[4]) ? id_sel : sr_new[6];
    assign sr_merged[5] = 1'b0;
    assign sr_merged[4] = (sr_new[6] & sr_new[4]) ? id_lock : (id_lock | sr_new[4]);
    assign sr_merged[3:2] = sr_new[3:2];
    assign sr_merged[1:0] = 2'h0;

    // page buffer loads in place, offset wraps inside the page
    always @(posedge i_clock) begin
        if (byte_done && state == ST_DATA && is_write) begin
            page_buf[col] <= new_byte;
        end
    end

    // main command engine
    always @(posedge i_clock or negedge rst_b) begin
        if (!rst_b) begin
            state <= ST_OP;
            bit_cnt <= 3'h0;
            shift_in <= 7'h00;
            addr <= 16'h0000;
            col <= 7'h00;
            start_col <= 7'h00;
            loaded <= 8'h00;
            is_write <= 1'b0;
            wel_pend <= 1'b0;
            sr_new <= 8'h00;
            sr_got <= 1'b0;
            so_shift <= 8'h00;
            o_so <= 1'b0;
            write_enable_latch_bit <= 1'b0;
            busy <= 1'b0;
            bp <= `SPIPW_RST_BP;
            id_lock <= `SPIPW_RST_ID_LOCK;
            id_sel <= 1'b0;
            hwp_en <= `SPIPW_RST_HWP_EN;
            timer <= 20'h00000;
            feed_col <= 7'h00;
            feed_left <= 8'h00;
            feed_page <= 16'h0000;
            feed_id <= 1'b0;
        end else begin
            // push loaded bytes into the programming queue
            if (feeding && fifo_in_ready) begin
                feed_col <= feed_col + 7'h01;
                feed_left <= feed_left - 8'h01;
            end
            // write cycle ends after the time and the queue have run out
            if (busy) begin
                if (timer != 20'h00000) begin
                    timer <= timer - 20'h00001;
                end else if (!feeding && !o_prog_valid) begin
                    busy <= 1'b0;
                    write_enable_latch_bit <= 1'b0;
                end
            end
            // serial output changes on falling clock during status read
            if (sck_fall && state == ST_SR_RD) begin
                o_so <= so_shift[7];
                so_shift <= {so_shift[6:0], so_shift[7]};
            end
            // bit shifting and byte decode on rising clock
            if (sck_rise) begin
                shift_in <= new_byte[6:0];
                bit_cnt <= bit_cnt + 3'h1;
                wel_pend <= 1'b0;
            end
            if (byte_done) begin
                case (state)
                    ST_OP: begin
                        if (busy) begin
                            // only status read runs during a write cycle
                            if (new_byte == `SPIPW_OP_SR_READ) begin
                                state <= ST_SR_RD;
                                so_shift <= status_val;
                            end else begin
                                state <= ST_IGNORE;
                            end
                        end else if (new_byte == `SPIPW_OP_SET_WEL) begin
                            wel_pend <= 1'b1;
                            state <= ST_IGNORE;
                        end else if (new_byte == `SPIPW_OP_CLR_WEL) begin
                            write_enable_latch_bit <= 1'b0;
                            state <= ST_IGNORE;
                        end else if (new_byte == `SPIPW_OP_SR_READ) begin
                            so_shift <= status_val;
                            state <= ST_SR_RD;
                        end else if (new_byte == `SPIPW_OP_SR_WRITE) begin
                            sr_got <= 1'b0;
                            state <= ST_SR_WR;
                        end else if (new_byte == `SPIPW_OP_MEM_READ ||
                                     new_byte == `SPIPW_OP_MEM_WRITE) begin
                            is_write <= (new_byte == `SPIPW_OP_MEM_WRITE);
                            loaded <= 8'h00;
                            state <= ST_ADDR_HI;
                        end else begin
                            state <= ST_IGNORE;
                        end
                    end
                    ST_ADDR_HI: begin
                        addr[15:8] <= new_byte;
                        state <= ST_ADDR_LO;
                    end
                    ST_ADDR_LO: begin
                        // full sixteen address clocks even for the id page
                        addr[7:0] <= new_byte;
                        col <= new_byte[6:0];
                        start_col <= new_byte[6:0];
                        state <= ST_DATA;
                    end
                    ST_DATA: begin
                        col <= col + 7'h01;
                        if (loaded != `SPIPW_PAGE_BYTES) begin
                            loaded <= loaded + 8'h01;
                        end
                    end
                    ST_SR_WR: begin
                        if (!sr_got) begin
                            sr_new <= new_byte;
                            sr_got <= 1'b1;
                        end
                    end
                    default: begin
                        state <= state;
                    end
                endcase
            end
            // a frame ends on select rising; act only on whole bytes
            if (cs_rise) begin
                state <= ST_OP;
                bit_cnt <= 3'h0;
                wel_pend <= 1'b0;
                if (bit_cnt == 3'h0) begin
                    if (wel_pend) begin
                        write_enable_latch_bit <= 1'b1;
                    end
                    if (state == ST_DATA && is_write && loaded != 8'h00 && mem_ok) begin
                        busy <= 1'b1;
                        timer <= TWC_COUNT;
                        feed_col <= start_col;
                        feed_left <= loaded;
                        feed_page <= id_sel ? 16'h0000 : {addr[15:7], 7'h00};
                        feed_id <= id_sel;
                    end
                    if (state == ST_DATA) begin
                        id_sel <= 1'b0;
                    end
                    if (state == ST_SR_WR && sr_got && sr_ok) begin
                        busy <= 1'b1;
                        timer <= TWC_COUNT;
                        hwp_en <= sr_merged[7];
                        id_sel <= sr_merged[6];
                        id_lock <= sr_merged[4];
                        bp <= sr_merged[3:2];
                    end
                end
            end
        end
    end

    // output driven only while selected and answering a status read
    assign o_so_oe = cs_low & (state == ST_SR_RD);

    // queue entry: id flag, address, data
    assign fifo_in = {feed_id, feed_page[15:7], feed_col, page_buf[feed_col]};

    spipw_fifo #(
        .WIDTH(25),
        .DEPTH(4),
        .AW(2)
    ) u_fifo (
        .i_clock(i_clock),
        .i_rst_b(rst_b),
        .i_in_valid(feeding),
        .i_in_data(fifo_in),
        .o_in_ready(fifo_in_ready),
        .o_out_valid(o_prog_valid),
        .o_out_data(fifo_out),
        .i_out_ready(i_prog_ready)
    );

    assign o_prog_id_page = fifo_out[24];
    assign o_prog_addr = fifo_out[23:8];
    assign o_prog_data = fifo_out[7:0];
endmodule

// [spipw_monitor.sv]
// checker for the serial memory core: select framing, busy and latch
// timing, programming port hold and in-page address stepping
// assumes it sees only the core's ports, bound onto every core instance
`timescale 1ns/1ps
module spipw_monitor #(
    parameter WRITE_CYCLES = 100000
) (
    // clock and reset
    input wire i_clock,
    input wire i_rst_b,
    // serial bus pins
    input wire i_sck,
    input wire i_cs_b,
    input wire i_si,
    input wire i_wp_b,
    input wire o_so,
    input wire o_so_oe,
    // cell programming port
    input wire o_prog_valid,
    input wire [15:0] o_prog_addr,
    input wire o_prog_id_page,
    input wire [7:0] o_prog_data,
    input wire i_prog_ready,
    // status view
    input wire [7:0] o_status
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    int busy_cnt;

    // length of the current busy stretch
    always @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= o_status[0] ? busy_cnt + 1 : 0;
        end
    end

    property p_so_float;
        i_cs_b [*4] |-> !o_so_oe;
    endproperty
    a_so_float: assert property (p_so_float) else $error("so driven while deselected");

    property p_zero_bit;
        o_status[5] == 1'b0;
    endproperty
    a_zero_bit: assert property (p_zero_bit) else $error("status bit 5 not zero");

    property p_busy_on_select_high;
        $rose(o_status[0]) |-> i_cs_b && $past(i_cs_b);
    endproperty
    a_busy_on_select_high: assert property (p_busy_on_select_high) else $error("busy began in frame");

    property p_latch_needed;
        $rose(o_status[0]) |-> o_status[1];
    endproperty
    a_latch_needed: assert property (p_latch_needed) else $error("write began without latch");

    property p_latch_cleared;
        $fell(o_status[0]) |-> !o_status[1];
    endproperty
    a_latch_cleared: assert property (p_latch_cleared) else $error("latch kept after write");

    property p_no_latch_while_busy;
        $rose(o_status[1]) |-> !$past(o_status[0]);
    endproperty
    a_no_latch_while_busy: assert property (p_no_latch_while_busy) else $error("latch set while busy");

    property p_busy_len;
        $fell(o_status[0]) |-> busy_cnt >= WRITE_CYCLES - 1;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle too short");

    property p_word_hold;
        o_prog_valid && !i_prog_ready |=> o_prog_valid
            && $stable({o_prog_id_page, o_prog_addr, o_prog_data});
    endproperty
    a_word_hold: assert property (p_word_hold) else $error("word changed before taken");

    property p_page_step;
        o_prog_valid && i_prog_ready ##1 o_prog_valid |->
            o_prog_addr == {$past(o_prog_addr[15:7]), $past(o_prog_addr[6:0]) + 7'h01};
    endproperty
    a_page_step: assert property (p_page_step) else $error("address left the page");

    property p_status_frame;
        !i_cs_b [*4] |-> $stable(o_status[7:2]);
    endproperty
    a_status_frame: assert property (p_status_frame) else $error("status changed in frame");
endmodule

bind spipw_core spipw_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) mon_u (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_sck(i_sck), .i_cs_b(i_cs_b),
    .i_si(i_si), .i_wp_b(i_wp_b), .o_so(o_so), .o_so_oe(o_so_oe),
    .o_prog_valid(o_prog_valid), .o_prog_addr(o_prog_addr),
    .o_prog_id_page(o_prog_id_page), .o_prog_data(o_prog_data),
    .i_prog_ready(i_prog_ready), .o_status(o_status)
);

// [spipw_host.sv]
// serial host model: frames queued bytes out on si, collects so bits
// assumes it drives on falling i_clock edges, sck half period four clocks
`timescale 1ns/1ps
module spipw_host (
    // system clock
    input wire i_clock,
    // serial pins
    input wire i_so,
    input wire i_so_oe,
    output logic o_sck,
    output logic o_cs_b,
    output logic o_si
);
    logic [7:0] tx[$];
    logic [7:0] rx;
    logic cpol;

    // idle bus at time zero
    initial begin
        o_sck = 1'b0;
        o_cs_b = 1'b1;
        o_si = 1'b0;
        rx = 8'h00;
        cpol = 1'b0;
    end

    // one framed transfer; cut drops trailing bits of the last byte
    task automatic run(input int cut);
        int n;
        int b;
        logic [7:0] v;
        n = tx.size();
        @(negedge i_clock);
        o_sck = cpol;
        repeat (4) @(negedge i_clock);
        o_cs_b = 1'b0;
        repeat (4) @(negedge i_clock);
        for (int i = 0; i < n; i++) begin
            v = tx.pop_front();
            for (b = 7; b >= ((i == n - 1) ? cut : 0); b--) begin
                o_sck = 1'b0;
                o_si = v[b];
                repeat (4) @(negedge i_clock);
                o_sck = 1'b1;
                repeat (4) @(negedge i_clock);
                rx = {rx[6:0], i_so_oe ? i_so : ~rx[0]};
            end
        end
        o_sck = cpol;
        repeat (4) @(negedge i_clock);
        o_cs_b = 1'b1;
        o_si = ~o_si; // released line shows no stale value
        repeat (8) @(negedge i_clock);
    endtask
endmodule

// [tb_top.sv]
// self-checking bench for the serial memory core
// assumes the host model drives the pins and this bench is the cell programmer
`timescale 1ns/1ps
module tb_top;
    logic i_clock = 1'b0;
    logic i_rst_b = 1'b0;
    logic i_wp_b = 1'b1;
    logic rdy = 1'b0;
    logic [31:0] rr;
    logic [15:0] ra;
    wire sck, cs_b, si, so, so_oe, pv, pid;
    wire [15:0] pa;
    wire [7:0] pd, st;
    logic [24:0] expq[$];
    int mismatches = 0;
    int checks_done = 0;

    // clock
    initial begin
        forever #25 i_clock = ~i_clock;
    end

    spipw_core #(.WRITE_CYCLES(200)) dut_u (
        .i_clock(i_clock), .i_rst_b(i_rst_b), .i_sck(sck), .i_cs_b(cs_b), .i_si(si),
        .i_wp_b(i_wp_b), .o_so(so), .o_so_oe(so_oe), .o_prog_valid(pv),
        .o_prog_addr(pa), .o_prog_id_page(pid), .o_prog_data(pd),
        .i_prog_ready(rdy), .o_status(st)
    );
    spipw_host host (
        .i_clock(i_clock), .i_so(so), .i_so_oe(so_oe), .o_sck(sck), .o_cs_b(cs_b),
        .o_si(si)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // random clock mode per frame
    task automatic send(input int cut);
        logic [31:0] r;
        r = $urandom;
        host.cpol = r[0];
        host.run(cut);
    endtask

    task automatic op1(input logic [7:0] a);
        host.tx = '{a};
        send(0);
    endtask

    task automatic wait_idle;
        for (int k = 0; k < 3000 && st[0] !== 1'b0; k++) @(negedge i_clock);
        if (st[0] !== 1'b0) begin
            mismatches++;
            wrap_up;
        end
    endtask

    task automatic status_write_cmd(input logic [7:0] v);
        op1(8'h06);
        host.tx = '{8'h01, v};
        send(0);
        wait_idle;
    endtask

    // memory write; expected words noted when it should be accepted
    task automatic wr(input logic [15:0] a, input int n, input bit en, input bit ok,
                      input bit id);
        logic [7:0] d;
        logic [6:0] o;
        if (en) op1(8'h06);
        host.tx = '{8'h02, a[15:8], a[7:0]};
        for (int k = 0; k < n; k++) begin
            d = $urandom;
            o = a[6:0] + k[6:0];
            host.tx.push_back(d);
            if (ok) expq.push_back({id, id ? 9'h000 : a[15:7], o, d});
        end
        send(0);
    endtask

    // programmer side stalls at random; a word shown with ready up is taken
    // at the next rising edge, so compare it now while it stands
    always @(negedge i_clock) begin
        rr = $urandom;
        rdy = (rr[1:0] != 2'h0);
        if (pv === 1'b1 && rdy === 1'b1) begin
            chk({pid, pa, pd}, expq.size() ? {7'h00, expq.pop_front()} : 32'hffffffff);
        end
    end

    // watchdog
    initial begin
        repeat (60000) @(posedge i_clock);
        mismatches++;
        wrap_up;
    end

    // main sequence
    initial begin
        void'($urandom(21));
        repeat (10) @(negedge i_clock);
        i_rst_b = 1'b1;
        repeat (6) @(negedge i_clock);
        chk(st, 8'h00);
        op1(8'h06);
        chk(st, 8'h02);
        host.tx = '{8'h05, 8'h00};
        send(0);
        chk(host.rx, 8'h02);
        op1(8'h5a);
        chk(st, 8'h02);
        op1(8'h04);
        chk(st, 8'h00);
        host.tx = '{8'h06};
        send(1);
        chk(st, 8'h00);
        ra = $urandom;
        ra[6:0] = 7'h7e;
        wr(ra, 4, 1, 1, 0);
        op1(8'h06);
        wait_idle;
        chk(st, 8'h00);
        wr(ra, 2, 0, 0, 0);
        wait_idle;
        chk(st, 8'h00);
        status_write_cmd(8'hff);
        chk(st, 8'h8c);
        wr(16'h0000, 1, 1, 0, 0);
        wait_idle;
        chk(st & 8'hfc, 8'h8c);
        i_wp_b = 1'b0;
        status_write_cmd(8'h00);
        chk(st & 8'hfc, 8'h8c);
        i_wp_b = 1'b1;
        status_write_cmd(8'h04);
        chk(st, 8'h04);
        wr(16'hc010, 1, 1, 0, 0);
        wr(16'h8010, 3, 1, 1, 0);
        wait_idle;
        chk(st, 8'h04);
        status_write_cmd(8'h44);
        chk(st, 8'h44);
        wr(16'hfe7f, 2, 1, 1, 1);
        wait_idle;
        chk(st, 8'h04);
        status_write_cmd(8'h44);
        host.tx = '{8'h03, 8'h12, 8'h34};
        send(0);
        chk(st, 8'h04);
        status_write_cmd(8'h14);
        chk(st, 8'h14);
        status_write_cmd(8'h44);
        chk(st, 8'h54);
        wr(16'h0005, 1, 1, 0, 1);
        wait_idle;
        chk(st & 8'hfc, 8'h14);
        status_write_cmd(8'h00);
        chk(st, 8'h10);
        repeat (20) @(negedge i_clock);
        chk(expq.size(), 0);
        wrap_up;
    end
endmodule
